/* hdl/uart_serial_pkg.sv */
// Package: register map, field layout, reset values and types of the UART core
package uart_serial_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIVIDER_OFS = 8'h04;
  localparam logic [7:0] MATCH_OFS = 8'h08;
  localparam logic [7:0] FIFO_CTRL_OFS = 8'h0c;
  localparam logic [7:0] EVENT_MASK_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] TX_DATA_OFS = 8'h18;
  localparam logic [7:0] RX_DATA_OFS = 8'h1c;
  // Reset values and control writable mask
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WRITABLE = 32'h000f_ffff;
  localparam logic [28:0] DIVIDER_RESET = 29'h0000_0000;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  localparam logic [20:0] FIFO_CTRL_RESET = 21'h00_0000;
  localparam logic [1:0] EVENT_MASK_RESET = 2'h0;
  // Field positions
  localparam int DIV_FRAC_LSB = 0;
  localparam int DIV_INT_LSB = 5;
  localparam int MATCH_ADDR_LSB = 0;
  localparam int MATCH_MASK_LSB = 8;
  localparam int RX_TRIG_LSB = 0;
  localparam int TX_TRIG_LSB = 8;
  localparam int RTS_LEVEL_LSB = 16;
  localparam int ST_RX_COUNT_LSB = 0;
  localparam int ST_TX_COUNT_LSB = 8;
  localparam int ST_RX_TRIG_BIT = 16;
  localparam int ST_TX_TRIG_BIT = 17;
  localparam int ST_TX_BUSY_BIT = 18;
  localparam int TX_ADDR_FLAG_BIT = 8;
  // Submode encodings and fixed IrDA oversampling
  localparam logic [1:0] SUBMODE_STANDARD = 2'h0;
  localparam logic [1:0] SUBMODE_SMARTCARD = 2'h1;
  localparam logic [1:0] SUBMODE_IRDA = 2'h2;
  localparam logic [3:0] IRDA_OVS = 4'h0;
  // FIFO geometry
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int FIFO_CW = 5;
  // Control register layout
  typedef struct packed {
    logic [11:0] spare;
    logic nack_retransmit_enable;
    logic receive_line_invert;
    logic store_matched_address;
    logic multiproc_enable;
    logic frame_fail_discard;
    logic parity_fail_discard;
    logic stop_two;
    logic parity_odd;
    logic parity_enable;
    logic msb_first_select;
    logic clear_to_send_enable;
    logic clear_to_send_polarity;
    logic request_to_send_polarity;
    logic [1:0] serial_submode;
    logic [3:0] oversample;
    logic enable;
  } ctrl_t;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage

/* hdl/uart_serial_core.sv */
// UART core: Wishbone registers, fractional divider, TX/RX engines, FIFOs
// Notes on behaviour
// - Bit time lasts oversample field plus one divider ticks.
// - Divider has 24-bit integer and 5-bit fraction in 1/32 steps.
// - Bit order LSB or MSB first on both directions.
// - Frame with bad parity dropped or stored per discard setting.
// - Frame with framing error dropped or stored per discard setting.
// - Multiprocessor address compared under mask; stored only if enabled.
// - Receive line inverted before sampling when enabled.
// - Smartcard with retry resends a frame answered by NACK.
// - With CTS enabled a frame starts only while CTS asserted.
// - CTS active low when polarity 0, else active high.
// - RTS polarity selectable, 0 active low; asserted by RX level.
// - RX event when RX fill exceeds trigger; masked onto output.
// - TX event when TX fill below trigger; masked onto output.
// - RX FIFO fill level readable in status.
// - RX data read returns and removes oldest entry.
// - TX data write appends one entry; no writes when full.
// - Submode 0 standard, 1 smartcard, 2 IrDA; code 3 acts as standard.
// - Normal IrDA forces oversampling setting zero.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module uart_sync_fifo #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic [uart_serial_pkg::FIFO_CW-1:0] count,
  output logic full,
  output logic empty
);
  logic [W-1:0] mem [uart_serial_pkg::FIFO_DEPTH];
  logic [uart_serial_pkg::FIFO_AW-1:0] wptr;
  logic [uart_serial_pkg::FIFO_AW-1:0] rptr;
  logic do_push;
  logic do_pop;

  assign full = count[uart_serial_pkg::FIFO_CW-1];
  assign empty = (count == '0);
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign rdata = mem[rptr];

  // Storage
  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wptr] <= wdata;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wptr <= wptr + 1'b1;
      end
      if (do_pop) begin
        rptr <= rptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

module uart_serial_core (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output var logic [31:0] WB_DAT_O,
  output var logic WB_ACK,
  input wire logic RXD,
  input wire logic CTS,
  output var logic TXD,
  output var logic RTS,
  output var logic RX_EVENT,
  output var logic TX_EVENT
);
  uart_serial_pkg::ctrl_t ctrl;
  logic [28:0] divider;
  logic [15:0] match;
  logic [20:0] fifo_ctrl;
  logic [1:0] event_mask;
  logic req;
  logic take;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] next_rdata;
  logic [23:0] div_int;
  logic [4:0] div_frac;
  logic [23:0] div_cnt;
  logic [23:0] div_reload;
  logic [4:0] frac_acc;
  logic [5:0] frac_sum;
  logic tick;
  logic [3:0] ovs_eff;
  logic rxd_meta, rxd_sync, cts_meta, cts_sync;
  logic rx_line, rx_prev;
  logic cts_ok;
  logic tx_push, tx_pop, tx_empty;
  logic [8:0] tx_head;
  logic [4:0] tx_count;
  logic rx_push, rx_pop, rx_empty;
  logic [7:0] rx_head;
  logic [4:0] rx_count;
  logic rx_trig, tx_trig;
  uart_serial_pkg::tx_state_t tx_state;
  logic [3:0] tx_os;
  logic [2:0] tx_idx;
  logic [8:0] tx_frame;
  logic [7:0] tx_shift;
  logic [7:0] head_rev, frame_rev;
  logic nack_seen;
  uart_serial_pkg::rx_state_t rx_state;
  logic [3:0] rx_os;
  logic [2:0] rx_idx;
  logic [7:0] rx_shift;
  logic rx_par, rx_ferr, rx_done, mp_matched;
  logic rx_perr, rx_drop, rx_is_addr, rx_addr_hit;

  // Bus request, byte lane merge
  assign req = WB_CYC & WB_STB & ~WB_ACK;
  assign take = WB_CYC & WB_STB & WB_ACK; // Effects land on the acked edge
  assign wmask = {{8{WB_SEL[3]}}, {8{WB_SEL[2]}},
                  {8{WB_SEL[1]}}, {8{WB_SEL[0]}}};
  assign wval = next_rdata & ~wmask | WB_DAT_I & wmask;
  assign tx_push = take & WB_WE & (WB_ADR == uart_serial_pkg::TX_DATA_OFS)
                   & WB_SEL[0];
  assign rx_pop = take & ~WB_WE & (WB_ADR == uart_serial_pkg::RX_DATA_OFS);

  // Single-cycle acknowledge for every address
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      WB_ACK <= 1'b0;
    end else begin
      WB_ACK <= req;
    end
  end

  // Configuration registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl <= uart_serial_pkg::CTRL_RESET;
      divider <= uart_serial_pkg::DIVIDER_RESET;
      match <= uart_serial_pkg::MATCH_RESET;
      fifo_ctrl <= uart_serial_pkg::FIFO_CTRL_RESET;
      event_mask <= uart_serial_pkg::EVENT_MASK_RESET;
    end else if (take && WB_WE) begin
      unique case (WB_ADR)
        uart_serial_pkg::CTRL_OFS: begin
          ctrl <= wval & uart_serial_pkg::CTRL_WRITABLE;
        end
        uart_serial_pkg::DIVIDER_OFS: begin
          divider <= wval[28:0];
        end
        uart_serial_pkg::MATCH_OFS: begin
          match <= wval[15:0];
        end
        uart_serial_pkg::FIFO_CTRL_OFS: begin
          fifo_ctrl <= wval[20:0] & 21'h1f_1f1f;
        end
        uart_serial_pkg::EVENT_MASK_OFS: begin
          if (WB_SEL[0]) begin
            event_mask <= WB_DAT_I[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read multiplexer; unmapped and write-only read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (WB_ADR)
      uart_serial_pkg::CTRL_OFS: next_rdata = ctrl;
      uart_serial_pkg::DIVIDER_OFS: next_rdata = {3'h0, divider};
      uart_serial_pkg::MATCH_OFS: next_rdata = {16'h0, match};
      uart_serial_pkg::FIFO_CTRL_OFS: next_rdata = {11'h0, fifo_ctrl};
      uart_serial_pkg::EVENT_MASK_OFS: next_rdata = {30'h0, event_mask};
      uart_serial_pkg::STATUS_OFS: begin
        next_rdata[uart_serial_pkg::ST_RX_COUNT_LSB +: 5] = rx_count;
        next_rdata[uart_serial_pkg::ST_TX_COUNT_LSB +: 5] = tx_count;
        next_rdata[uart_serial_pkg::ST_RX_TRIG_BIT] = rx_trig;
        next_rdata[uart_serial_pkg::ST_TX_TRIG_BIT] = tx_trig;
        next_rdata[uart_serial_pkg::ST_TX_BUSY_BIT] =
          (tx_state != uart_serial_pkg::TX_IDLE);
      end
      uart_serial_pkg::RX_DATA_OFS: begin
        next_rdata[7:0] = rx_empty ? 8'h00 : rx_head;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (req && !WB_WE) begin
      WB_DAT_O <= next_rdata;
    end else begin
      WB_DAT_O <= 32'h0000_0000;
    end
  end

  // Fractional divider: period int or int+1, fraction carries extra cycle
  assign div_int = divider[uart_serial_pkg::DIV_INT_LSB +: 24];
  assign div_frac = divider[uart_serial_pkg::DIV_FRAC_LSB +: 5];
  assign frac_sum = {1'b0, frac_acc} + {1'b0, div_frac};
  assign div_reload = (div_int == 24'h00_0000) ? 24'h00_0000
                      : div_int - 24'h00_0001 + {23'h0, frac_sum[5]};

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      div_cnt <= 24'h00_0000;
      frac_acc <= 5'h00;
      tick <= 1'b0;
    end else if (!ctrl.enable) begin
      div_cnt <= 24'h00_0000;
      frac_acc <= 5'h00;
      tick <= 1'b0;
    end else if (div_cnt == 24'h00_0000) begin
      tick <= 1'b1;
      frac_acc <= frac_sum[4:0];
      div_cnt <= div_reload;
    end else begin
      tick <= 1'b0;
      div_cnt <= div_cnt - 24'h00_0001;
    end
  end

  // Oversampling factor, fixed in normal IrDA
  assign ovs_eff = (ctrl.serial_submode == uart_serial_pkg::SUBMODE_IRDA)
                   ? uart_serial_pkg::IRDA_OVS : ctrl.oversample;

  // Pin synchronisers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
    end else begin
      rxd_meta <= RXD;
      rxd_sync <= rxd_meta;
      cts_meta <= CTS;
      cts_sync <= cts_meta;
    end
  end

  assign rx_line = rxd_sync ^ ctrl.receive_line_invert;
  assign cts_ok = !ctrl.clear_to_send_enable
                  || (cts_sync == ctrl.clear_to_send_polarity);

  uart_sync_fifo #(.W(9)) tx_fifo (
    .clock(CLOCK),
    .rstn(RSTN),
    .push(tx_push),
    .wdata(WB_DAT_I[8:0]),
    .pop(tx_pop),
    .rdata(tx_head),
    .count(tx_count),
    .full(),
    .empty(tx_empty)
  );

  uart_sync_fifo #(.W(8)) rx_fifo (
    .clock(CLOCK),
    .rstn(RSTN),
    .push(rx_push),
    .wdata(rx_shift),
    .pop(rx_pop),
    .rdata(rx_head),
    .count(rx_count),
    .full(),
    .empty(rx_empty)
  );

  assign tx_pop = (tx_state == uart_serial_pkg::TX_IDLE) && tick
                  && !tx_empty && cts_ok;

  // Bit-reversed copies for MSB-first shifting
  assign head_rev = {<<{tx_head[7:0]}};
  assign frame_rev = {<<{tx_frame[7:0]}};

  // Transmitter
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      tx_state <= uart_serial_pkg::TX_IDLE;
      tx_os <= 4'h0;
      tx_idx <= 3'h0;
      tx_frame <= 9'h000;
      tx_shift <= 8'h00;
      nack_seen <= 1'b0;
      TXD <= 1'b1;
    end else if (tx_state == uart_serial_pkg::TX_IDLE) begin
      TXD <= 1'b1;
      if (tx_pop) begin
        tx_frame <= tx_head;
        tx_shift <= ctrl.msb_first_select ? head_rev : tx_head[7:0];
        tx_state <= uart_serial_pkg::TX_START;
        tx_os <= 4'h0;
        tx_idx <= 3'h0;
        TXD <= 1'b0;
      end
    end else if (tick && tx_os != ovs_eff) begin
      tx_os <= tx_os + 4'h1;
      if (tx_os == (ovs_eff >> 1) && tx_state == uart_serial_pkg::TX_STOP) begin
        nack_seen <= ~rx_line;
      end
    end else if (tick) begin
      tx_os <= 4'h0;
      unique case (tx_state)
        uart_serial_pkg::TX_START: begin
          TXD <= tx_shift[0];
          tx_shift <= tx_shift >> 1;
          tx_state <= uart_serial_pkg::TX_DATA;
        end
        uart_serial_pkg::TX_DATA: begin
          tx_idx <= tx_idx + 3'h1;
          if (tx_idx != 3'h7) begin
            TXD <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
          end else if (ctrl.multiproc_enable) begin
            TXD <= tx_frame[uart_serial_pkg::TX_ADDR_FLAG_BIT];
            tx_state <= uart_serial_pkg::TX_PARITY;
          end else if (ctrl.parity_enable) begin
            TXD <= ^tx_frame[7:0] ^ ctrl.parity_odd;
            tx_state <= uart_serial_pkg::TX_PARITY;
          end else begin
            TXD <= 1'b1;
            nack_seen <= 1'b0;
            tx_state <= uart_serial_pkg::TX_STOP;
          end
        end
        uart_serial_pkg::TX_PARITY: begin
          TXD <= 1'b1;
          nack_seen <= 1'b0;
          tx_state <= uart_serial_pkg::TX_STOP;
        end
        uart_serial_pkg::TX_STOP: begin
          tx_idx <= tx_idx + 3'h1;
          if (ctrl.stop_two && tx_idx == 3'h0) begin
            TXD <= 1'b1;
          end else if (ctrl.serial_submode == uart_serial_pkg::SUBMODE_SMARTCARD
                       && ctrl.nack_retransmit_enable && nack_seen) begin
            TXD <= 1'b0;
            tx_idx <= 3'h0;
            tx_shift <= ctrl.msb_first_select ? frame_rev : tx_frame[7:0];
            tx_state <= uart_serial_pkg::TX_START;
          end else begin
            TXD <= 1'b1;
            tx_state <= uart_serial_pkg::TX_IDLE;
          end
        end
        default: tx_state <= uart_serial_pkg::TX_IDLE;
      endcase
    end
  end

  // Receiver bit engine
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rx_state <= uart_serial_pkg::RX_IDLE;
      rx_prev <= 1'b1;
      rx_os <= 4'h0;
      rx_idx <= 3'h0;
      rx_shift <= 8'h00;
      rx_par <= 1'b0;
      rx_ferr <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      rx_prev <= rx_line;
      rx_done <= 1'b0;
      if (rx_state == uart_serial_pkg::RX_IDLE) begin
        if (ctrl.enable && rx_prev && !rx_line) begin
          rx_state <= uart_serial_pkg::RX_START;
          rx_os <= 4'h0;
          rx_idx <= 3'h0;
        end
      end else if (rx_state == uart_serial_pkg::RX_START) begin
        if (tick && rx_os == (ovs_eff >> 1)) begin
          rx_os <= 4'h0;
          rx_state <= rx_line ? uart_serial_pkg::RX_IDLE
                      : uart_serial_pkg::RX_DATA;
        end else if (tick) begin
          rx_os <= rx_os + 4'h1;
        end
      end else if (tick && rx_os != ovs_eff) begin
        rx_os <= rx_os + 4'h1;
      end else if (tick) begin
        rx_os <= 4'h0;
        unique case (rx_state)
          uart_serial_pkg::RX_DATA: begin
            rx_idx <= rx_idx + 3'h1;
            rx_shift <= ctrl.msb_first_select ? {rx_shift[6:0], rx_line}
                        : {rx_line, rx_shift[7:1]};
            if (rx_idx == 3'h7) begin
              rx_state <= (ctrl.parity_enable || ctrl.multiproc_enable)
                          ? uart_serial_pkg::RX_PARITY
                          : uart_serial_pkg::RX_STOP;
            end
          end
          uart_serial_pkg::RX_PARITY: begin
            rx_par <= rx_line;
            rx_state <= uart_serial_pkg::RX_STOP;
          end
          uart_serial_pkg::RX_STOP: begin
            rx_ferr <= ~rx_line;
            rx_done <= 1'b1;
            rx_state <= uart_serial_pkg::RX_IDLE;
          end
          default: rx_state <= uart_serial_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // Frame acceptance: error discard and address filter
  assign rx_perr = ctrl.parity_enable && !ctrl.multiproc_enable
                   && (rx_par != (^rx_shift ^ ctrl.parity_odd));
  assign rx_drop = (rx_perr && ctrl.parity_fail_discard)
                   || (rx_ferr && ctrl.frame_fail_discard);
  assign rx_is_addr = ctrl.multiproc_enable && rx_par;
  assign rx_addr_hit = ((rx_shift ^ match[uart_serial_pkg::MATCH_ADDR_LSB +: 8])
                        & match[uart_serial_pkg::MATCH_MASK_LSB +: 8]) == 8'h00;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rx_push <= 1'b0;
      mp_matched <= 1'b0;
    end else if (rx_done && rx_is_addr) begin
      mp_matched <= rx_addr_hit;
      rx_push <= rx_addr_hit && ctrl.store_matched_address && !rx_drop;
    end else if (rx_done) begin
      rx_push <= !rx_drop && (!ctrl.multiproc_enable || mp_matched);
    end else begin
      rx_push <= 1'b0;
    end
  end

  // Trigger events, flow control output
  assign rx_trig = rx_count > fifo_ctrl[uart_serial_pkg::RX_TRIG_LSB +: 5];
  assign tx_trig = tx_count < fifo_ctrl[uart_serial_pkg::TX_TRIG_LSB +: 5];

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RX_EVENT <= 1'b0;
      TX_EVENT <= 1'b0;
      RTS <= 1'b1;
    end else begin
      RX_EVENT <= rx_trig && event_mask[0];
      TX_EVENT <= tx_trig && event_mask[1];
      RTS <= (rx_count < fifo_ctrl[uart_serial_pkg::RTS_LEVEL_LSB +: 5])
             ? ctrl.request_to_send_polarity
             : ~ctrl.request_to_send_polarity;
    end
  end
endmodule

`default_nettype wire

/* dv/uart_peer.sv */
// Far-end serial device model: frame sender and frame catcher
`timescale 1ns/1ps
`default_nettype none
module uart_peer (
  input wire logic clock,
  input wire logic txd,
  output logic rxd
);
  logic inv;
  initial begin
    inv = 1'b0;
    rxd = 1'b1;
  end
  // Change line sense, park at the inverted idle level
  task automatic set_inv(input logic v);
    inv = v;
    @(posedge clock);
    rxd <= ~v;
    repeat (8) @(posedge clock);
  endtask
  // Send start, data LSB first, optional slot, stop; idle high
  task automatic send(input logic [7:0] d, input logic pen,
                      input logic pbit, input logic stopv, input int bitc);
    logic [10:0] f;
    int n;
    n = pen ? 11 : 10;
    f = pen ? {stopv, pbit, d, 1'b0} : {1'b1, stopv, d, 1'b0};
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rxd <= f[i] ^ inv;
      repeat (bitc - 1) @(posedge clock);
    end
    @(posedge clock);
    rxd <= ~inv;
    repeat (2 * bitc) @(posedge clock);
  endtask
  // Catch one frame on its start edge, sample mid bit; stop in bit 8
  task automatic recv(input int bitc, output logic [8:0] got);
    int w;
    w = 0;
    got = 'x;
    do begin
      @(posedge clock);
      w++;
    end while (txd !== 1'b0 && w < 400);
    if (w < 400) begin
      for (int i = 0; i < 9; i++) begin
        repeat (i == 0 ? bitc + bitc / 2 : bitc) @(posedge clock);
        got[i] = txd;
      end
    end
  endtask
endmodule
`default_nettype wire

/* dv/uart_serial_chk.sv */
// Checker: bus timing, event masking and register readback
`timescale 1ns/1ps
`default_nettype none
module uart_serial_chk (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK,
  input wire logic RXD,
  input wire logic CTS,
  input wire logic TXD,
  input wire logic RTS,
  input wire logic RX_EVENT,
  input wire logic TX_EVENT
);
  logic [31:0] ctrl_m;
  logic [1:0] mask_m;
  logic take_wr;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // Write taken on this edge
  assign take_wr = WB_CYC && WB_STB && WB_ACK && WB_WE;
  // Mirror of the control register, byte lanes honoured
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_m <= uart_serial_pkg::CTRL_RESET;
    end else if (take_wr && WB_ADR == uart_serial_pkg::CTRL_OFS) begin
      for (int b = 0; b < 4; b++) begin
        if (WB_SEL[b]) begin
          ctrl_m[8*b +: 8] <= WB_DAT_I[8*b +: 8];
        end
      end
    end
  end
  // Mirror of the event mask
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      mask_m <= uart_serial_pkg::EVENT_MASK_RESET;
    end else if (take_wr && WB_SEL[0] &&
                 WB_ADR == uart_serial_pkg::EVENT_MASK_OFS) begin
      mask_m <= WB_DAT_I[1:0];
    end
  end
  sequence s_req;
    WB_CYC && WB_STB && !WB_ACK;
  endsequence
  sequence s_ans;
    WB_ACK ##1 !WB_ACK;
  endsequence
  sequence s_rd(logic [7:0] a);
    WB_ACK && !WB_WE && WB_ADR == a;
  endsequence
  a_ack_after_req: assert property (s_req |=> s_ans)
    else $error("ack not one cycle after request");
  a_ack_needs_req: assert property ($rose(WB_ACK) |-> $past(WB_STB))
    else $error("ack without request");
  a_dat_quiet: assert property (!WB_ACK |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  a_rx_event_mask: assert property (RX_EVENT |-> $past(mask_m[0]))
    else $error("receive event while masked");
  a_tx_event_mask: assert property (TX_EVENT |-> $past(mask_m[1]))
    else $error("transmit event while masked");
  a_txd_idle_reset: assert property ($rose(RSTN) |-> TXD && RTS)
    else $error("line not idle after reset");
  a_ctrl_readback: assert property (s_rd(uart_serial_pkg::CTRL_OFS) |->
    WB_DAT_O == (ctrl_m & uart_serial_pkg::CTRL_WRITABLE))
    else $error("control readback wrong");
  a_mask_readback: assert property (s_rd(uart_serial_pkg::EVENT_MASK_OFS)
    |-> WB_DAT_O == {30'h0, mask_m})
    else $error("mask readback wrong");
endmodule
bind uart_serial_core uart_serial_chk u_chk (.CLOCK(CLOCK), .RSTN(RSTN),
  .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR),
  .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK(WB_ACK), .RXD(RXD), .CTS(CTS), .TXD(TXD), .RTS(RTS),
  .RX_EVENT(RX_EVENT), .TX_EVENT(TX_EVENT));
`default_nettype wire

/* dv/tb.sv */
// Testbench: register, transmit, receive and flow-control scenarios
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLOCK, RSTN, WB_CYC, WB_STB, WB_WE, CTS;
  logic [7:0] WB_ADR;
  logic [3:0] WB_SEL;
  logic [31:0] WB_DAT_I, WB_DAT_O, q;
  logic WB_ACK, RXD, TXD, RTS, RX_EVENT, TX_EVENT;
  logic [8:0] got;
  logic [31:0] dv [4] = '{32'h20, 32'h30, 32'h20, 32'h20};
  logic [31:0] cv [4] = '{32'h7, 32'h7, 32'h47, 32'h407};
  logic [7:0] tx [4] = '{8'ha5, 8'h96, 8'h6b, 8'h1e};
  int bc [4] = '{4, 6, 1, 4};
  int err_total, compares, n_low;
  uart_serial_core i_dut (.CLOCK(CLOCK), .RSTN(RSTN), .WB_CYC(WB_CYC),
    .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK), .RXD(RXD),
    .CTS(CTS), .TXD(TXD), .RTS(RTS), .RX_EVENT(RX_EVENT),
    .TX_EVENT(TX_EVENT));
  uart_peer i_peer (.clock(CLOCK), .txd(TXD), .rxd(RXD));
  // 20 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  function automatic logic [7:0] rev(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = v[7-i];
    return r;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] a);
    compares++;
    if (a !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, a);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLOCK);
    WB_CYC <= 1'b1;
    WB_STB <= 1'b1;
    WB_WE <= we;
    WB_ADR <= a;
    WB_DAT_I <= d;
    do begin
      @(posedge CLOCK);
      n++;
    end while (WB_ACK !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    q = WB_DAT_O;
    WB_CYC <= 1'b0;
    WB_STB <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  task automatic conclude;
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(50 * 30000);
    err_total++;
    conclude;
  end
  initial begin
    {RSTN, WB_CYC, WB_STB, WB_WE, CTS} = 5'h0;
    WB_ADR = 8'h0;
    WB_SEL = 4'hf;
    WB_DAT_I = 32'h0;
    err_total = 0;
    compares = 0;
    repeat (20) @(posedge CLOCK);
    RSTN <= 1'b1;
    // Reset value, reserved bits, unmapped space
    rdc(uart_serial_pkg::CTRL_OFS, 32'hffff_ffff, 32'h0, "ctrl");
    wr(uart_serial_pkg::CTRL_OFS, 32'hffff_fffe);
    rdc(uart_serial_pkg::CTRL_OFS, 32'hffff_ffff, 32'hf_fffe, "ctrl");
    wr(8'h20, 32'hffff_ffff);
    rdc(8'h20, 32'hffff_ffff, 32'h0, "unmapped");
    // Transmit event follows mask
    wr(uart_serial_pkg::FIFO_CTRL_OFS, 32'h0002_0101);
    wr(uart_serial_pkg::EVENT_MASK_OFS, 32'h3);
    rdc(uart_serial_pkg::EVENT_MASK_OFS, 32'h3, 32'h3, "mask");
    repeat (3) @(posedge CLOCK);
    chk("tx_event", 32'h1, {31'h0, TX_EVENT});
    wr(uart_serial_pkg::EVENT_MASK_OFS, 32'h1);
    repeat (3) @(posedge CLOCK);
    chk("tx_event", 32'h0, {31'h0, TX_EVENT});
    // Transmit across divider, oversampling, submode and bit order
    for (int k = 0; k < 4; k++) begin
      wr(uart_serial_pkg::DIVIDER_OFS, dv[k]);
      wr(uart_serial_pkg::CTRL_OFS, cv[k]);
      fork
        wr(uart_serial_pkg::TX_DATA_OFS, {24'h0, tx[k]});
        i_peer.recv(bc[k], got);
      join
      chk("tx_frame", {1'b1, k == 3 ? rev(tx[k]) : tx[k]}, got);
    end
    // Transmitter held off while clear-to-send is negated
    for (int p = 0; p < 2; p++) begin
      CTS <= ~p[0];
      wr(uart_serial_pkg::CTRL_OFS, 32'h207 | (p << 8));
      wr(uart_serial_pkg::TX_DATA_OFS, 32'h55);
      n_low = 0;
      repeat (60) begin
        @(posedge CLOCK);
        if (TXD !== 1'b1) n_low++;
      end
      chk("cts_hold", 32'h0, n_low);
      fork
        CTS <= p[0];
        i_peer.recv(4, got);
      join
      chk("cts_frame", 32'h155, {23'h0, got});
    end
    // Receive with parity and framing faults, dropped or kept
    wr(uart_serial_pkg::CTRL_OFS, 32'h4807);
    i_peer.send(8'h5a, 1'b1, ^8'h5a, 1'b1, 4);
    i_peer.send(8'h33, 1'b1, ~^8'h33, 1'b1, 4);
    rdc(uart_serial_pkg::STATUS_OFS, 32'h1f, 32'h1, "rx_count");
    chk("rts", 32'h0, {31'h0, RTS});
    chk("rx_event", 32'h0, {31'h0, RX_EVENT});
    wr(uart_serial_pkg::CTRL_OFS, 32'h0807);
    i_peer.send(8'h33, 1'b1, ~^8'h33, 1'b1, 4);
    wr(uart_serial_pkg::CTRL_OFS, 32'h8807);
    i_peer.send(8'h0f, 1'b1, ^8'h0f, 1'b0, 4);
    wr(uart_serial_pkg::CTRL_OFS, 32'h0807);
    i_peer.send(8'h0f, 1'b1, ^8'h0f, 1'b0, 4);
    rdc(uart_serial_pkg::STATUS_OFS, 32'h1f, 32'h3, "rx_count");
    chk("rts", 32'h1, {31'h0, RTS});
    chk("rx_event", 32'h1, {31'h0, RX_EVENT});
    rdc(uart_serial_pkg::RX_DATA_OFS, 32'hff, 32'h5a, "rx_data");
    rdc(uart_serial_pkg::RX_DATA_OFS, 32'hff, 32'h33, "rx_data");
    rdc(uart_serial_pkg::RX_DATA_OFS, 32'hff, 32'h0f, "rx_data");
    rdc(uart_serial_pkg::RX_DATA_OFS, 32'hff, 32'h00, "rx_empty");
    // Address filter: unmatched address and its data skipped
    wr(uart_serial_pkg::MATCH_OFS, 32'hff42);
    wr(uart_serial_pkg::CTRL_OFS, 32'h3_0007);
    i_peer.send(8'h43, 1'b1, 1'b1, 1'b1, 4);
    i_peer.send(8'h22, 1'b1, 1'b0, 1'b1, 4);
    i_peer.send(8'h42, 1'b1, 1'b1, 1'b1, 4);
    rdc(uart_serial_pkg::RX_DATA_OFS, 32'hff, 32'h42, "mp_addr");
    // Inverted receive line
    wr(uart_serial_pkg::CTRL_OFS, 32'h4_0806);
    i_peer.set_inv(1'b1);
    wr(uart_serial_pkg::CTRL_OFS, 32'h4_0807);
    i_peer.send(8'hc3, 1'b1, ^8'hc3, 1'b1, 4);
    rdc(uart_serial_pkg::RX_DATA_OFS, 32'hff, 32'hc3, "rx_inv");
    // Line held low as refusal: smartcard sender repeats the frame
    wr(uart_serial_pkg::CTRL_OFS, 32'h8_8027);
    wr(uart_serial_pkg::TX_DATA_OFS, 32'h3c);
    i_peer.recv(4, got);
    i_peer.recv(4, got);
    chk("resend", 32'h13c, {23'h0, got});
    conclude;
  end
endmodule
`default_nettype wire
